// ---- pmc_core_model.sv ----
// Core and interrupt controller seen from the sequencer
module pmc_core_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       exc_start_q,
  output logic            sleep_insn,
  output logic            global_mask_flag,
  output logic            timer_a_irq,
  output logic [3:0]      ext_request_lines,
  output logic [7:0]      edge_wake_inputs,
  output logic            other_irq
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [13:0] req_q;
  assign {other_irq, edge_wake_inputs, ext_request_lines, timer_a_irq} = req_q;
  initial begin
    sleep_insn = 1'b0;
    global_mask_flag = 1'b0;
    req_q = 14'h0000;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Handler acknowledges every pending level once its exception starts
  always @(posedge pclk) begin
    if (!presetn || exc_start_q) begin
      req_q <= 14'h0000;
    end
  end
  task automatic do_sleep();
    @(posedge pclk);
    sleep_insn <= 1'b1;
    @(posedge pclk);
    sleep_insn <= 1'b0;
  endtask
  // Lag lets the controller answer late as well as promptly
  task automatic raise(input logic [13:0] r, input int lag);
    @(posedge pclk);
    repeat (lag) @(posedge pclk);
    req_q <= req_q | r;
  endtask
  // Only the bench chooses the mask; never set around a direct transfer
  task automatic set_mask(input logic v);
    @(posedge pclk);
    global_mask_flag <= v;
  endtask
endmodule

// ---- pmc_defs.svh ----
`ifndef PMC_DEFS_SVH
`define PMC_DEFS_SVH

// Register byte offsets
`define PMC_OFF_CTRL1   8'h00
`define PMC_OFF_CTRL2   8'h04
`define PMC_OFF_TMODE   8'h08
`define PMC_OFF_IEN     8'h0C
`define PMC_OFF_STAT    8'h10

// system_control_one fields
`define PMC_C1_SSEL     0
`define PMC_C1_LOW_SPEED_ON     1
`define PMC_C1_STS_LO   2
`define PMC_C1_STS_HI   4
`define PMC_C1_MDIV_LO  5
`define PMC_C1_MDIV_HI  6
// system_control_two fields
`define PMC_C2_MEDIUM_SPEED_ON     0
`define PMC_C2_DIRECT_TRANSFER_ON     1
`define PMC_C2_SDIV_LO  2
`define PMC_C2_SDIV_HI  3
// timer_a_mode_reg field
`define PMC_TM_WSEL     0
// Enable fields
`define PMC_IE_TA       0
`define PMC_IE_EXT_LO   1
`define PMC_IE_EXT_HI   4
`define PMC_IE_EDG_LO   5
`define PMC_IE_EDG_HI   12
`define PMC_IE_DT       13
`define PMC_IE_OTH      14

// Reset values
`define PMC_RST_CTRL1   7'h00
`define PMC_RST_CTRL2   4'h0
`define PMC_RST_IEN     15'h0000

// Shortest settling wait in states; codes 1..4 double it
`define PMC_SETTLE_BASE 8192
`define PMC_STS_MAXSH   3'h4

`endif

// ---- pmc_pkg.sv ----
package pmc_pkg;

  typedef enum logic [3:0] {
    PMC_HS_ACT   = 4'h0,
    PMC_HS_SLP   = 4'h1,
    PMC_MS_SLP   = 4'h2,
    PMC_MS_ACT   = 4'h3,
    PMC_STANDBY  = 4'h4,
    PMC_WATCH    = 4'h5,
    PMC_SUB_ACT  = 4'h6,
    PMC_SUB_SLP  = 4'h7,
    PMC_SETTLE   = 4'hC
  } pmc_mode_t;

endpackage

// ---- pmc_tb_top.sv ----
`include "pmc_defs.svh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin miscompares++; \
  $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, a, b); end end
module pmc_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic               pclk;
  logic               presetn;
  logic               psel;
  logic               penable;
  logic               pwrite;
  logic [7:0]         paddr;
  logic [31:0]        pwdata;
  logic [31:0]        prdata;
  logic               pready;
  logic               pslverr;
  logic               sleep_insn;
  logic               global_mask_flag;
  logic               timer_a_irq;
  logic [3:0]         ext_request_lines;
  logic [7:0]         edge_wake_inputs;
  logic               other_irq;
  pmc_pkg::pmc_mode_t mode_q;
  logic               cpu_halt_q;
  logic               slow_clk_sel_q;
  logic [1:0]         slow_div_log2_q;
  logic [1:0]         med_div_sel_q;
  logic               main_clk_hold_q;
  logic               port_freeze_q;
  logic               exc_start_q;
  logic               dt_exc_start_q;
  int                 miscompares = 0;
  int                 num_checks = 0;
  int                 n;
  logic [31:0]        rd;
  logic               er;

  pmc_top #(.SETTLE_BASE(4)) pmc_top_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sleep_insn(sleep_insn), .global_mask_flag(global_mask_flag),
    .timer_a_irq(timer_a_irq), .ext_request_lines(ext_request_lines),
    .edge_wake_inputs(edge_wake_inputs), .other_irq(other_irq),
    .mode_q(mode_q), .cpu_halt_q(cpu_halt_q), .slow_clk_sel_q(slow_clk_sel_q),
    .slow_div_log2_q(slow_div_log2_q), .med_div_sel_q(med_div_sel_q),
    .main_clk_hold_q(main_clk_hold_q), .port_freeze_q(port_freeze_q),
    .exc_start_q(exc_start_q), .dt_exc_start_q(dt_exc_start_q));
  pmc_core_model pmc_core_model_inst (.pclk(pclk), .presetn(presetn),
    .exc_start_q(exc_start_q), .sleep_insn(sleep_insn),
    .global_mask_flag(global_mask_flag), .timer_a_irq(timer_a_irq),
    .ext_request_lines(ext_request_lines),
    .edge_wake_inputs(edge_wake_inputs), .other_irq(other_irq));

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // Waits for pready with no limit of its own; the watchdog ends a hang
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Let the write settle so callers see the updated outputs
    #1;
  endtask
  task automatic cfg(input logic [31:0] c1, input logic [31:0] c2,
                     input logic [31:0] ws);
    apb(1'b1, `PMC_OFF_CTRL1, c1);
    apb(1'b1, `PMC_OFF_CTRL2, c2);
    apb(1'b1, `PMC_OFF_TMODE, ws);
  endtask
  task automatic step();
    @(posedge pclk);
    #1;
  endtask
  // Counts edges until the mode appears, so settling length is measured
  task automatic wait_mode(input pmc_pkg::pmc_mode_t m, input int lim);
    n = 0;
    while (mode_q !== m && n < lim) begin
      step();
      n++;
    end
    `CHK(mode_q, m)
  endtask
  task automatic slp();
    pmc_core_model_inst.do_sleep();
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    `CHK(mode_q, pmc_pkg::PMC_HS_ACT)
    `CHK(slow_div_log2_q, 2'h3)
    apb(1'b0, `PMC_OFF_CTRL2, 32'h0000_0000);
    `CHK(rd, 32'h0000_0000)
    apb(1'b0, 8'h14, 32'h0000_0000);
    `CHK(er, 1'b1)
    `CHK(rd, 32'h0000_0000)
    apb(1'b1, `PMC_OFF_IEN, 32'h0000_5A5A);
    apb(1'b0, `PMC_OFF_IEN, 32'h0000_0000);
    `CHK(rd, 32'h0000_5A5A)
    `CHK(er, 1'b0)
    $display("test reset done");
  endtask
  task automatic t_sleep_hs();
    apb(1'b1, `PMC_OFF_IEN, 32'h0000_3FFF);
    cfg(32'h0, 32'h0, 32'h0);
    slp();
    `CHK(mode_q, pmc_pkg::PMC_HS_SLP)
    `CHK(cpu_halt_q, 1'b1)
    pmc_core_model_inst.raise(14'h2000, 0);
    repeat (4) step();
    `CHK(mode_q, pmc_pkg::PMC_HS_SLP)
    pmc_core_model_inst.set_mask(1'b1);
    apb(1'b1, `PMC_OFF_IEN, 32'h0000_7FFF);
    repeat (4) step();
    `CHK(mode_q, pmc_pkg::PMC_HS_SLP)
    pmc_core_model_inst.set_mask(1'b0);
    wait_mode(pmc_pkg::PMC_HS_ACT, 10);
    `CHK(exc_start_q, 1'b1)
    $display("test sleep high done");
  endtask
  task automatic t_medium();
    cfg(32'h40, 32'h1, 32'h0);
    `CHK(med_div_sel_q, 2'h2)
    slp();
    `CHK(mode_q, pmc_pkg::PMC_MS_SLP)
    pmc_core_model_inst.raise(14'h0008, 0);
    wait_mode(pmc_pkg::PMC_MS_ACT, 10);
    `CHK(exc_start_q, 1'b1)
    cfg(32'h45, 32'h1, 32'h0);
    slp();
    `CHK(mode_q, pmc_pkg::PMC_STANDBY)
    `CHK(main_clk_hold_q, 1'b1)
    pmc_core_model_inst.raise(14'h0004, 0);
    wait_mode(pmc_pkg::PMC_SETTLE, 10);
    wait_mode(pmc_pkg::PMC_MS_ACT, 100);
    `CHK(n, 8)
    `CHK(exc_start_q, 1'b1)
    cfg(32'h01, 32'h1, 32'h1);
    slp();
    `CHK(mode_q, pmc_pkg::PMC_WATCH)
    pmc_core_model_inst.raise(14'h0001, 0);
    wait_mode(pmc_pkg::PMC_SETTLE, 10);
    wait_mode(pmc_pkg::PMC_MS_ACT, 20);
    `CHK(n, 4)
    `CHK(exc_start_q, 1'b1)
    $display("test medium done");
  endtask
  task automatic t_direct();
    cfg(32'h0, 32'h2, 32'h0);
    slp();
    `CHK(mode_q, pmc_pkg::PMC_MS_SLP)
    step();
    `CHK(mode_q, pmc_pkg::PMC_HS_ACT)
    `CHK(dt_exc_start_q, 1'b1)
    cfg(32'h0, 32'h3, 32'h0);
    slp();
    `CHK(mode_q, pmc_pkg::PMC_HS_SLP)
    step();
    `CHK(mode_q, pmc_pkg::PMC_MS_ACT)
    cfg(32'h3, 32'h2, 32'h1);
    slp();
    `CHK(mode_q, pmc_pkg::PMC_WATCH)
    step();
    `CHK(mode_q, pmc_pkg::PMC_SUB_ACT)
    `CHK(slow_clk_sel_q, 1'b1)
    $display("test direct done");
  endtask
  task automatic t_sub();
    apb(1'b1, `PMC_OFF_CTRL2, 32'h0000_000A);
    `CHK(slow_div_log2_q, 2'h3)
    cfg(32'h2, 32'h0, 32'h1);
    slp();
    `CHK(mode_q, pmc_pkg::PMC_SUB_SLP)
    `CHK(port_freeze_q, 1'b1)
    pmc_core_model_inst.raise(14'h0100, 0);
    wait_mode(pmc_pkg::PMC_SUB_ACT, 10);
    `CHK(exc_start_q, 1'b1)
    cfg(32'h3, 32'h0, 32'h1);
    slp();
    `CHK(mode_q, pmc_pkg::PMC_WATCH)
    pmc_core_model_inst.raise(14'h0001, 3);
    wait_mode(pmc_pkg::PMC_SUB_ACT, 10);
    cfg(32'h1D, 32'h2, 32'h1);
    slp();
    `CHK(mode_q, pmc_pkg::PMC_WATCH)
    step();
    `CHK(mode_q, pmc_pkg::PMC_SETTLE)
    wait_mode(pmc_pkg::PMC_HS_ACT, 200);
    `CHK(n, 64)
    apb(1'b1, `PMC_OFF_CTRL2, 32'h0000_0004);
    `CHK(slow_div_log2_q, 2'h2)
    apb(1'b1, `PMC_OFF_CTRL2, 32'h0000_0008);
    `CHK(slow_div_log2_q, 2'h1)
    $display("test subactive done");
  endtask
  task automatic t_reset_mid();
    // Direct-transfer source disabled: the sleep must stay a plain sleep
    apb(1'b1, `PMC_OFF_IEN, 32'h0000_5FFF);
    cfg(32'h0, 32'h2, 32'h0);
    slp();
    `CHK(mode_q, pmc_pkg::PMC_HS_SLP)
    step();
    `CHK(mode_q, pmc_pkg::PMC_HS_SLP)
    `CHK(dt_exc_start_q, 1'b0)
    @(posedge pclk);
    presetn <= 1'b0;
    #1;
    `CHK(mode_q, pmc_pkg::PMC_HS_ACT)
    `CHK(cpu_halt_q, 1'b0)
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    step();
    step();
    `CHK(mode_q, pmc_pkg::PMC_HS_ACT)
    `CHK(slow_div_log2_q, 2'h3)
    `CHK(cpu_halt_q, 1'b0)
    $display("test reset mid done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    step();
    t_reset();
    t_sleep_hs();
    t_medium();
    t_direct();
    t_sub();
    t_reset_mid();
    stop_test();
  end
  // Whole run is well under a thousand cycles
  initial begin
    repeat (5000) @(posedge pclk);
    miscompares++;
    stop_test();
  end
endmodule

// ---- pmc_top.sv ----
// Chosen here: the register offsets and the APB interface to the registers.
`include "pmc_defs.svh"

// Operation
// - Subactive sleep with low_speed_on, wsel, no standby_select: subsleep
// - Subsleep wakes on timer A, request, edge
// - Mask flag or disabled source blocks wake-up
// - Watch wakes to subactive when low_speed_on set
// - Subactive sleep with standby_select and wsel: watch
// - Subactive sleep, no standby_select, low_speed_on, wsel: subsleep
// - Subactive clock is slow clock over 2/4/8
// - Divider 00:8 01:4 1x:2, locked in subactive
// - Medium wake from standby, watch, medium sleep
// - Medium sleep with standby_select, no low_speed_on/wsel: standby
// - Medium sleep with standby_select and wsel: watch
// - Sleep without standby_select/low_speed_on: high or medium sleep
// - Reset pin abandons every mode at once
// - Medium mode clock follows medium divider
// - Direct transfer halts the CPU while passing through, then exception
// - Direct-transfer source disabled: plain sleep/watch
// - High to medium via sleep
// - Medium to high via sleep
// - High or medium to subactive via watch
// - Subactive to high via watch and wait
// - Subactive to medium via watch and wait
// - Leaving watch for active waits for oscillator
// - Settling 8192 doubling to 65536, top 131072
module pmc_top #(
  parameter int unsigned SETTLE_BASE = `PMC_SETTLE_BASE
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic               sleep_insn,
  input  wire logic               global_mask_flag,
  input  wire logic               timer_a_irq,
  input  wire logic [3:0]         ext_request_lines,
  input  wire logic [7:0]         edge_wake_inputs,
  input  wire logic               other_irq,
  output pmc_pkg::pmc_mode_t      mode_q,
  output logic                    cpu_halt_q,
  output logic                    slow_clk_sel_q,
  output logic [1:0]              slow_div_log2_q,
  output logic [1:0]              med_div_sel_q,
  output logic                    main_clk_hold_q,
  output logic                    port_freeze_q,
  output logic                    exc_start_q,
  output logic                    dt_exc_start_q
);

  typedef struct packed {
    pmc_pkg::pmc_mode_t mode;
    pmc_pkg::pmc_mode_t target;
    logic               dt;
    logic [17:0]        cnt;
    logic [6:0]         ctrl1;
    logic [3:0]         ctrl2;
    logic               wsel;
    logic [14:0]        ien;
    logic [31:0]        rdata;
    logic               rdy;
    logic               err;
    logic               halt;
    logic               slow;
    logic [1:0]         sdiv;
    logic [1:0]         mdiv;
    logic               hold;
    logic               frz;
    logic               exc;
    logic               dtexc;
  } pmc_state_t;

  pmc_state_t q;
  pmc_state_t d;

  ////////////////////////////////////////////////////////////////////
  // Field views and gated wake sources

  logic        ssel;
  logic        low_speed_on;
  logic [2:0]  sts;
  logic        medium_speed_on;
  logic        direct_transfer_on;
  logic        wk_ta;
  logic [3:0]  wk_ext;
  logic [7:0]  wk_edg;
  logic        wk_any;
  logic        wake_ok;
  logic        dt_ok;
  logic        sleep_go;
  logic [2:0]  sts_sh;
  logic [17:0] settle_ld;
  logic        acc;
  logic        setup;
  logic        hit;
  logic [31:0] rd_mux;

  assign ssel = q.ctrl1[`PMC_C1_SSEL];
  assign low_speed_on = q.ctrl1[`PMC_C1_LOW_SPEED_ON];
  assign sts  = q.ctrl1[`PMC_C1_STS_HI:`PMC_C1_STS_LO];
  assign medium_speed_on = q.ctrl2[`PMC_C2_MEDIUM_SPEED_ON];
  assign direct_transfer_on = q.ctrl2[`PMC_C2_DIRECT_TRANSFER_ON];

  // Disabled sources never wake anything
  assign wk_ta  = timer_a_irq & q.ien[`PMC_IE_TA];
  assign wk_ext = ext_request_lines
                & q.ien[`PMC_IE_EXT_HI:`PMC_IE_EXT_LO];
  assign wk_edg = edge_wake_inputs
                & q.ien[`PMC_IE_EDG_HI:`PMC_IE_EDG_LO];
  assign wk_any = wk_ta | (|wk_ext) | (|wk_edg)
                | (other_irq & q.ien[`PMC_IE_OTH]);
  assign wake_ok = !global_mask_flag;
  // A masked direct transfer degrades to plain sleep or watch
  assign dt_ok   = direct_transfer_on & q.ien[`PMC_IE_DT] & !global_mask_flag;

  // Sleep is decoded only in the executing modes
  assign sleep_go = sleep_insn & ((q.mode == pmc_pkg::PMC_HS_ACT)
                  | (q.mode == pmc_pkg::PMC_MS_ACT)
                  | (q.mode == pmc_pkg::PMC_SUB_ACT));

  // Any code with the top bit set takes the longest wait
  assign sts_sh = sts[2] ? `PMC_STS_MAXSH : sts;
  assign settle_ld = 18'((SETTLE_BASE << sts_sh) - 1);

  ////////////////////////////////////////////////////////////////////
  // APB slave: one wait-free access phase, unmapped is an error

  assign setup = psel & !penable;
  assign acc   = psel & penable & q.rdy;
  assign hit   = (paddr == `PMC_OFF_CTRL1) | (paddr == `PMC_OFF_CTRL2)
               | (paddr == `PMC_OFF_TMODE) | (paddr == `PMC_OFF_IEN)
               | (paddr == `PMC_OFF_STAT);

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      `PMC_OFF_CTRL1: rd_mux = {25'h0, q.ctrl1};
      `PMC_OFF_CTRL2: rd_mux = {28'h0, q.ctrl2};
      `PMC_OFF_TMODE: rd_mux = {31'h0, q.wsel};
      `PMC_OFF_IEN:   rd_mux = {17'h0, q.ien};
      `PMC_OFF_STAT:  rd_mux = {26'h0, q.dt,
                                q.mode == pmc_pkg::PMC_SETTLE, q.mode};
      default:        rd_mux = 32'h0000_0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    d       = q;
    d.rdy   = setup;
    d.err   = setup & !hit;
    d.exc   = 1'b0;
    d.dtexc = 1'b0;
    if (setup) begin
      d.rdata = rd_mux;
    end
    if (acc & pwrite & hit) begin
      case (paddr)
        `PMC_OFF_CTRL1: d.ctrl1 = pwdata[6:0];
        `PMC_OFF_CTRL2: begin
          d.ctrl2[1:0] = pwdata[1:0];
          // Clock divider must not change under a running slow CPU
          if (q.mode != pmc_pkg::PMC_SUB_ACT) begin
            d.ctrl2[3:2] = pwdata[3:2];
          end
        end
        `PMC_OFF_TMODE: d.wsel = pwdata[0];
        `PMC_OFF_IEN:   d.ien = pwdata[14:0];
        default:        d.wsel = q.wsel;
      endcase
    end

    case (q.mode)
      pmc_pkg::PMC_HS_ACT,
      pmc_pkg::PMC_MS_ACT: begin
        if (sleep_go) begin
          if (dt_ok & ssel & low_speed_on & q.wsel) begin
            d.mode   = pmc_pkg::PMC_WATCH;
            d.target = pmc_pkg::PMC_SUB_ACT;
            d.dt     = 1'b1;
          end else if (dt_ok & !ssel & !low_speed_on
                       & (medium_speed_on != (q.mode == pmc_pkg::PMC_MS_ACT))) begin
            d.mode   = medium_speed_on ? pmc_pkg::PMC_HS_SLP
                            : pmc_pkg::PMC_MS_SLP;
            d.target = medium_speed_on ? pmc_pkg::PMC_MS_ACT
                            : pmc_pkg::PMC_HS_ACT;
            d.dt     = 1'b1;
          end else if (ssel & q.wsel) begin
            d.mode = pmc_pkg::PMC_WATCH;
          end else if (ssel & !low_speed_on) begin
            d.mode = pmc_pkg::PMC_STANDBY;
          end else if (!ssel & !low_speed_on) begin
            d.mode = medium_speed_on ? pmc_pkg::PMC_MS_SLP
                          : pmc_pkg::PMC_HS_SLP;
          end
        end
      end
      pmc_pkg::PMC_SUB_ACT: begin
        if (sleep_go & ssel & q.wsel) begin
          d.mode = pmc_pkg::PMC_WATCH;
          if (dt_ok & !low_speed_on) begin
            d.target = medium_speed_on ? pmc_pkg::PMC_MS_ACT
                            : pmc_pkg::PMC_HS_ACT;
            d.dt     = 1'b1;
          end
        end else if (sleep_go & !ssel & low_speed_on & q.wsel) begin
          d.mode = pmc_pkg::PMC_SUB_SLP;
        end
      end
      pmc_pkg::PMC_HS_SLP,
      pmc_pkg::PMC_MS_SLP: begin
        if (q.dt) begin
          // Pass-through: the program is halted for this one cycle only
          d.mode  = q.target;
          d.dt    = 1'b0;
          d.dtexc = 1'b1;
        end else if (wk_any & wake_ok) begin
          d.mode = (q.mode == pmc_pkg::PMC_MS_SLP)
                 ? pmc_pkg::PMC_MS_ACT
                 : pmc_pkg::PMC_HS_ACT;
          d.exc  = 1'b1;
        end
      end
      pmc_pkg::PMC_STANDBY: begin
        if ((|wk_ext[1:0]) & wake_ok) begin
          d.mode   = pmc_pkg::PMC_SETTLE;
          d.target = medium_speed_on ? pmc_pkg::PMC_MS_ACT
                          : pmc_pkg::PMC_HS_ACT;
          d.cnt    = settle_ld;
        end
      end
      pmc_pkg::PMC_WATCH: begin
        if (q.dt & (q.target == pmc_pkg::PMC_SUB_ACT)) begin
          d.mode  = pmc_pkg::PMC_SUB_ACT;
          d.dt    = 1'b0;
          d.dtexc = 1'b1;
        end else if (q.dt) begin
          d.mode = pmc_pkg::PMC_SETTLE;
          d.cnt  = settle_ld;
        end else if ((wk_ta | wk_ext[0]) & wake_ok) begin
          if (low_speed_on) begin
            d.mode = pmc_pkg::PMC_SUB_ACT;
            d.exc  = 1'b1;
          end else begin
            d.mode   = pmc_pkg::PMC_SETTLE;
            d.target = medium_speed_on ? pmc_pkg::PMC_MS_ACT
                            : pmc_pkg::PMC_HS_ACT;
            d.cnt    = settle_ld;
          end
        end
      end
      pmc_pkg::PMC_SUB_SLP: begin
        if ((wk_ta | (|wk_ext) | (|wk_edg)) & wake_ok) begin
          d.mode = pmc_pkg::PMC_SUB_ACT;
          d.exc  = 1'b1;
        end
      end
      pmc_pkg::PMC_SETTLE: begin
        if (q.cnt == 18'h00000) begin
          d.mode  = q.target;
          d.exc   = !q.dt;
          d.dtexc = q.dt;
          d.dt    = 1'b0;
        end else begin
          d.cnt = q.cnt - 18'h00001;
        end
      end
      default: d.mode = pmc_pkg::PMC_HS_ACT;
    endcase

    // Halt, slow select, hold and freeze follow the next mode; dividers follow the next register fields
    d.halt = (d.mode != pmc_pkg::PMC_HS_ACT)
           & (d.mode != pmc_pkg::PMC_MS_ACT)
           & (d.mode != pmc_pkg::PMC_SUB_ACT);
    d.slow = (d.mode == pmc_pkg::PMC_SUB_ACT)
           | (d.mode == pmc_pkg::PMC_SUB_SLP);
    d.sdiv = d.ctrl2[`PMC_C2_SDIV_HI] ? 2'h1
           : (d.ctrl2[`PMC_C2_SDIV_LO] ? 2'h2 : 2'h3);
    d.mdiv = d.ctrl1[`PMC_C1_MDIV_HI:`PMC_C1_MDIV_LO];
    // Main clock is stopped until settling is over
    d.hold = (d.mode == pmc_pkg::PMC_STANDBY)
           | (d.mode == pmc_pkg::PMC_WATCH)
           | (d.mode == pmc_pkg::PMC_SETTLE) | d.slow;
    d.frz  = (d.mode == pmc_pkg::PMC_SUB_SLP)
           | (d.mode == pmc_pkg::PMC_WATCH);
  end

  ////////////////////////////////////////////////////////////////////
  // State register; the reset pin ends any mode at once

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q        <= '0;
      q.mode   <= pmc_pkg::PMC_HS_ACT;
      q.target <= pmc_pkg::PMC_HS_ACT;
      q.ctrl1  <= `PMC_RST_CTRL1;
      q.ctrl2  <= `PMC_RST_CTRL2;
      q.ien    <= `PMC_RST_IEN;
      q.sdiv   <= 2'h3;
    end else begin
      q <= d;
    end
  end

  assign prdata          = q.rdata;
  assign pready          = q.rdy;
  assign pslverr         = q.err;
  assign mode_q          = q.mode;
  assign cpu_halt_q      = q.halt;
  assign slow_clk_sel_q  = q.slow;
  assign slow_div_log2_q = q.sdiv;
  assign med_div_sel_q   = q.mdiv;
  assign main_clk_hold_q = q.hold;
  assign port_freeze_q   = q.frz;
  assign exc_start_q     = q.exc;
  assign dt_exc_start_q  = q.dtexc;

  ////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_subsleep_entry: assert property (
    sleep_insn && q.mode == pmc_pkg::PMC_SUB_ACT && !ssel && low_speed_on
    && q.wsel |=> q.mode == pmc_pkg::PMC_SUB_SLP && port_freeze_q)
    else $error("subsleep not entered");

  a_subsleep_wake: assert property (
    q.mode == pmc_pkg::PMC_SUB_SLP && wake_ok && (|wk_edg)
    |=> q.mode == pmc_pkg::PMC_SUB_ACT && exc_start_q)
    else $error("subsleep wake missed");

  a_mask_blocks: assert property (
    (q.mode == pmc_pkg::PMC_SUB_SLP || q.mode == pmc_pkg::PMC_HS_SLP
     || q.mode == pmc_pkg::PMC_MS_SLP || q.mode == pmc_pkg::PMC_STANDBY
     || q.mode == pmc_pkg::PMC_WATCH) && !q.dt && global_mask_flag
    |=> $stable(q.mode) && !exc_start_q)
    else $error("wake despite mask");

  a_watch_to_sub: assert property (
    q.mode == pmc_pkg::PMC_WATCH && !q.dt && low_speed_on && wake_ok
    && wk_ta |=> q.mode == pmc_pkg::PMC_SUB_ACT)
    else $error("watch wake to subactive missed");

  a_div_locked: assert property (
    q.mode == pmc_pkg::PMC_SUB_ACT && d.mode == pmc_pkg::PMC_SUB_ACT
    |=> $stable(q.ctrl2[3:2]))
    else $error("divider changed in subactive");

  a_standby_entry: assert property (
    sleep_insn && q.mode == pmc_pkg::PMC_MS_ACT && ssel && !low_speed_on
    && !q.wsel && !dt_ok |=> q.mode == pmc_pkg::PMC_STANDBY
    ##1 main_clk_hold_q)
    else $error("standby not entered");

  a_dt_hs_to_ms: assert property (
    sleep_insn && q.mode == pmc_pkg::PMC_HS_ACT && !ssel && !low_speed_on
    && medium_speed_on && dt_ok |=> q.mode == pmc_pkg::PMC_HS_SLP
    ##1 q.mode == pmc_pkg::PMC_MS_ACT && dt_exc_start_q)
    else $error("direct transfer high to medium failed");

  a_dt_fallback: assert property (
    sleep_insn && q.mode == pmc_pkg::PMC_HS_ACT && direct_transfer_on
    && !q.ien[`PMC_IE_DT] && !ssel && !low_speed_on
    |=> !q.dt ##1 !dt_exc_start_q)
    else $error("disabled direct transfer completed");

  a_settle_end: assert property (
    q.mode == pmc_pkg::PMC_SETTLE && q.cnt == 18'h00000
    |=> q.mode == $past(q.target) && !main_clk_hold_q
    && (exc_start_q != dt_exc_start_q))
    else $error("settling did not resume active mode");

  a_sub_clock: assert property (
    q.mode == pmc_pkg::PMC_SUB_ACT |-> slow_clk_sel_q
    && slow_div_log2_q != 2'h0 && !cpu_halt_q)
    else $error("subactive clock wrong");

  c_sub_round: cover property (
    q.mode == pmc_pkg::PMC_SUB_SLP ##1 q.mode == pmc_pkg::PMC_SUB_ACT);
  c_settle_done: cover property (
    q.mode == pmc_pkg::PMC_SETTLE ##1 q.mode == pmc_pkg::PMC_MS_ACT);
  c_dt_to_sub: cover property (
    q.mode == pmc_pkg::PMC_WATCH ##1 dt_exc_start_q);

endmodule
